/* File: rtl/smt_engine.sv */
// smt_engine: byte-oriented two-wire master transfer engine with data register
// assumes: open-drain pins resolved outside; control bits come as plain ports
//
// Operation
// - exactly one of four modes: master/slave transmitter/receiver at any time
// - start makes master; master held until arbitration loss or generated stop
// - byte_done_flag set at end of every byte frame
// - receive interrupt before ack without hw_ack_enable, after ack with it
// - transmit interrupt always after the ack cycle
// - master write: start, then address byte with direction bit 0
// - master read: start, then address byte with direction bit 1
// - write sends data bytes after address; slave acks each
// - write ends with stop once stop_request_bit set
// - no data write after transmitter interrupt turns master receiver
// - master read drives clock and samples data; slave sends bytes
// - no hw ack: set ack_request_flag, interrupt, then drive software ack value
// - hw ack: device drives ack/nack itself, then posts interrupt
// - hw ack uses ack bit value held when byte arrives
// - ack bit 1 drives acknowledge, 0 drives not-acknowledge
// - master receiver ends after stop_request_bit and generated stop
// - data write while master receiver turns master transmitter
// - bytes shift msb first; first received bit lands in msb
// - hw_ack_enable selects automatic acknowledge, else firmware acknowledges
`timescale 1ns/10ps
`default_nettype none
module smt_engine #(
   parameter int HALF_CYC = smt_pkg::SMT_SCL_HALF_CYC
) (
   // clock, reset, clock enable
   input  wire logic       mclk_i,
   input  wire logic       reset_n_i,
   input  wire logic       ce_i,
   // special-function register port
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   // control bits
   input  wire logic       enable_i,
   input  wire logic       hw_ack_enable_i,
   input  wire logic       start_set_i,
   input  wire logic       stop_set_i,
   input  wire logic       ack_wr_i,
   input  wire logic       ack_val_i,
   input  wire logic       done_clear_i,
   // status bits
   output logic            byte_done_flag_o,
   output logic            ack_request_flag_o,
   output logic            stop_request_bit_o,
   output logic            master_o,
   output logic            tx_mode_o,
   output logic            ack_bit_o,
   output logic            arb_lost_o,
   // open-drain bus pins
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o
);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

   smt_pkg::smt_state_t state;
   smt_pkg::smt_mode_t  mode;
   logic [7:0] data;        // serial_data_byte_reg, also the shift register
   logic [7:0] cnt;         // half-period counter
   logic [2:0] bitn;        // bit index within the byte
   logic       scl_low;
   logic       sda_low;
   logic       pin_level;   // level driven while an enable is high
   logic       tx;          // current byte is transmitted
   logic       addr_byte;   // current byte follows a start
   logic       wrote;       // data register written since last interrupt
   logic       start_pend;
   logic       stop_pend;
   logic       ack_bit;
   logic       ack_request_flag;
   logic       done_set_q;  // one-cycle request to set byte_done_flag
   logic       done_flag;
   logic       arb_lost;
   logic       scl_s;
   logic       sda_s;
   logic       half_done;
   logic       data_wr;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   smt_sync #(
      .WIDTH (2)
   ) u_sync (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .ce_i      (ce_i),
      .async_i   ({scl_i, sda_i}),
      .sync_o    ({scl_s, sda_s})
   );

   // shared decodes
   assign half_done = (cnt == HALF_LAST);
   assign data_wr   = sfr_wr_i && (sfr_addr_i == smt_pkg::SMT_DATA_ADDR);

   ////////////////////////////////////////////////////////////////////////
   // interrupt flag: set by the sequencer, cleared by software, set wins
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         done_flag <= 1'b0;
      end else if (ce_i) begin
         if (done_set_q) begin
            done_flag <= 1'b1;
         end else if (done_clear_i) begin
            done_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read port and output staging
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sfr_rdata_o <= 8'h00;
         pin_level   <= 1'b0;
      end else if (ce_i) begin
         sfr_rdata_o <= (sfr_addr_i == smt_pkg::SMT_DATA_ADDR) ? data : 8'h00;
         pin_level   <= 1'b0;
      end
   end

   assign scl_o              = pin_level;
   assign sda_o              = pin_level;
   assign scl_oe_o           = scl_low;
   assign sda_oe_o           = sda_low;
   assign byte_done_flag_o   = done_flag;
   assign ack_request_flag_o = ack_request_flag;
   assign stop_request_bit_o = stop_pend;
   assign master_o           = mode[1];
   assign tx_mode_o          = mode[0];
   assign ack_bit_o          = ack_bit;
   assign arb_lost_o         = arb_lost;

   ////////////////////////////////////////////////////////////////////////
   // software requests; a hardware clear of wrote in the same cycle loses to the set, the ack capture beats an ack write
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wrote   <= 1'b0;
         ack_bit <= 1'b0;
      end else if (ce_i) begin
         if (data_wr && (done_flag || state == smt_pkg::SMT_ST_IDLE)) begin
            wrote <= 1'b1;
         end else if (state == smt_pkg::SMT_ST_NEXT) begin
            wrote <= 1'b0;
         end
         if (state == smt_pkg::SMT_ST_ACK_HI && half_done && scl_s && tx) begin
            ack_bit <= ~sda_s; // received acknowledge shows in the ack bit
         end else if (ack_wr_i) begin
            ack_bit <= ack_val_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer: start, bits, acknowledge, stop, repeated start
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state      <= smt_pkg::SMT_ST_IDLE;
         mode       <= smt_pkg::SMT_MODE_SR;
         data       <= smt_pkg::SMT_DATA_RESET;
         cnt        <= 8'h00;
         bitn       <= 3'h0;
         scl_low    <= 1'b0;
         sda_low    <= 1'b0;
         tx         <= 1'b0;
         addr_byte  <= 1'b0;
         start_pend <= 1'b0;
         stop_pend  <= 1'b0;
         ack_request_flag      <= 1'b0;
         done_set_q <= 1'b0;
         arb_lost   <= 1'b0;
      end else if (ce_i) begin
         done_set_q <= 1'b0;
         cnt        <= half_done ? 8'h00 : cnt + 8'h01;
         if (start_set_i) begin
            start_pend <= 1'b1;
         end
         if (stop_set_i) begin
            stop_pend <= 1'b1;
         end
         if (data_wr && done_flag) begin
            data <= sfr_wdata_i;
         end
         unique case (state)
            smt_pkg::SMT_ST_IDLE: begin
               cnt <= 8'h00;
               if (data_wr) begin
                  data <= sfr_wdata_i;
               end
               if (start_pend && enable_i && scl_s && sda_s) begin
                  sda_low  <= 1'b1;
                  arb_lost <= 1'b0;
                  state    <= smt_pkg::SMT_ST_START;
               end else if (stop_pend && !start_pend && !stop_set_i) begin
                  stop_pend <= 1'b0; // nothing to stop
               end
            end
            smt_pkg::SMT_ST_START: begin
               if (half_done) begin
                  scl_low    <= 1'b1;
                  mode       <= smt_pkg::SMT_MODE_MT;
                  start_pend <= start_set_i;
                  addr_byte  <= 1'b1;
                  done_set_q <= 1'b1;
                  state      <= smt_pkg::SMT_ST_HOLD;
               end
            end
            smt_pkg::SMT_ST_HOLD: begin
               cnt     <= 8'h00;
               sda_low <= 1'b0;
               if (!done_flag && !done_set_q) begin
                  state <= smt_pkg::SMT_ST_NEXT;
               end
            end
            smt_pkg::SMT_ST_NEXT: begin
               cnt <= 8'h00;
               if (stop_pend) begin
                  sda_low <= 1'b1;
                  state   <= smt_pkg::SMT_ST_STOP_LO;
               end else if (start_pend) begin
                  sda_low <= 1'b0;
                  state   <= smt_pkg::SMT_ST_RS_LO;
               end else begin
                  // a written byte is sent, otherwise one is received
                  tx      <= wrote;
                  mode    <= wrote ? smt_pkg::SMT_MODE_MT : smt_pkg::SMT_MODE_MR;
                  sda_low <= 1'b0;
                  bitn    <= 3'h7;
                  state   <= smt_pkg::SMT_ST_BIT_LO;
               end
            end
            smt_pkg::SMT_ST_BIT_LO: begin
               if (cnt == 8'h00) begin
                  sda_low <= tx ? ~data[7] : 1'b0;
               end
               if (half_done) begin
                  scl_low <= 1'b0;
                  state   <= smt_pkg::SMT_ST_BIT_HI;
               end
            end
            smt_pkg::SMT_ST_BIT_HI: begin
               if (!scl_s) begin
                  cnt <= 8'h00; // slave stretching the clock
               end else if (half_done) begin
                  data <= {data[6:0], sda_s};
                  if (tx && !sda_low && !sda_s) begin
                     // lost arbitration: release the bus as slave
                     arb_lost <= 1'b1;
                     sda_low  <= 1'b0;
                     mode     <= smt_pkg::SMT_MODE_SR;
                     state    <= smt_pkg::SMT_ST_IDLE;
                  end else begin
                     scl_low <= 1'b1;
                     bitn    <= bitn - 3'h1;
                     if (bitn != 3'h0) begin
                        state <= smt_pkg::SMT_ST_BIT_LO;
                     end else if (!tx && !hw_ack_enable_i) begin
                        ack_request_flag      <= 1'b1;
                        done_set_q <= 1'b1;
                        state      <= smt_pkg::SMT_ST_ACK_REQUEST_FLAG;
                     end else begin
                        state <= smt_pkg::SMT_ST_ACK_LO;
                     end
                  end
               end
            end
            smt_pkg::SMT_ST_ACK_REQUEST_FLAG: begin
               cnt     <= 8'h00;
               sda_low <= 1'b0;
               if (!done_flag && !done_set_q) begin
                  ack_request_flag <= 1'b0;
                  state <= smt_pkg::SMT_ST_ACK_LO;
               end
            end
            smt_pkg::SMT_ST_ACK_LO: begin
               if (cnt == 8'h00) begin
                  sda_low <= tx ? 1'b0 : ack_bit;
               end
               if (half_done) begin
                  scl_low <= 1'b0;
                  state   <= smt_pkg::SMT_ST_ACK_HI;
               end
            end
            smt_pkg::SMT_ST_ACK_HI: begin
               if (!scl_s) begin
                  cnt <= 8'h00;
               end else if (half_done) begin
                  scl_low   <= 1'b1;
                  addr_byte <= 1'b0;
                  if (addr_byte && tx) begin
                     // direction bit of the address byte picks the mode
                     mode <= (data[0] == smt_pkg::SMT_DIR_READ) ?
                             smt_pkg::SMT_MODE_MR : smt_pkg::SMT_MODE_MT;
                  end
                  if (tx || hw_ack_enable_i) begin
                     done_set_q <= 1'b1;
                     state      <= smt_pkg::SMT_ST_HOLD;
                  end else begin
                     state <= smt_pkg::SMT_ST_NEXT;
                  end
               end
            end
            smt_pkg::SMT_ST_STOP_LO: begin
               if (half_done) begin
                  scl_low <= 1'b0;
                  state   <= smt_pkg::SMT_ST_STOP_HI;
               end
            end
            smt_pkg::SMT_ST_STOP_HI: begin
               if (!scl_s) begin
                  cnt <= 8'h00;
               end else if (half_done) begin
                  sda_low <= 1'b0;
                  state   <= smt_pkg::SMT_ST_STOP_END;
               end
            end
            smt_pkg::SMT_ST_STOP_END: begin
               if (half_done) begin
                  mode      <= smt_pkg::SMT_MODE_SR;
                  stop_pend <= stop_set_i;
                  state     <= smt_pkg::SMT_ST_IDLE;
               end
            end
            smt_pkg::SMT_ST_RS_LO: begin
               if (half_done) begin
                  scl_low <= 1'b0;
                  state   <= smt_pkg::SMT_ST_RS_HI;
               end
            end
            smt_pkg::SMT_ST_RS_HI: begin
               if (!scl_s) begin
                  cnt <= 8'h00;
               end else if (half_done) begin
                  sda_low <= 1'b1;
                  state   <= smt_pkg::SMT_ST_START;
               end
            end
            default: begin
               state <= smt_pkg::SMT_ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   idle_slave_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      state == smt_pkg::SMT_ST_IDLE |-> !mode[1])
      else $error("master mode while idle");

   master_entry_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      $rose(mode[1]) |-> $past(state) == smt_pkg::SMT_ST_START)
      else $error("master mode entered without a start");

   tx_irq_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
      (state == smt_pkg::SMT_ST_ACK_HI && half_done && scl_s && tx)
      |=> done_set_q ##1 done_flag)
      else $error("transmit interrupt missing after ack");

   hw_ack_irq_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
      (state == smt_pkg::SMT_ST_ACK_HI && half_done && scl_s && !tx && hw_ack_enable_i)
      |=> done_set_q && state == smt_pkg::SMT_ST_HOLD)
      else $error("hardware ack interrupt not after ack");

   ack_request_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
      (state == smt_pkg::SMT_ST_BIT_HI && half_done && scl_s && !tx && bitn == 3'h0
       && !hw_ack_enable_i) |=> ack_request_flag && done_set_q ##1 done_flag && scl_low)
      else $error("ack request not raised before ack");

   ack_drive_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (state == smt_pkg::SMT_ST_ACK_LO && !tx && cnt == 8'h01) |-> sda_low == ack_bit)
      else $error("ack value not driven");

   msb_first_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (state == smt_pkg::SMT_ST_BIT_LO && tx && bitn == 3'h7 && cnt == 8'h01)
      |-> sda_low == !data[7])
      else $error("first bit is not the msb");

   clock_held_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      done_flag |-> scl_low)
      else $error("clock released while interrupt pending");

   stop_exit_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
      (state == smt_pkg::SMT_ST_STOP_END && half_done)
      |=> !mode[1] && state == smt_pkg::SMT_ST_IDLE)
      else $error("master mode kept after stop");

   mode_switch_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i || !ce_i)
      (state == smt_pkg::SMT_ST_NEXT && !stop_pend && !start_pend)
      |=> (mode == smt_pkg::SMT_MODE_MT) == $past(wrote))
      else $error("mode change does not follow data write");

endmodule
`default_nettype wire

/* File: rtl/smt_pkg.sv */
// smt_pkg: shared constants and types of the smbus master transfer engine
// assumes: a 50 MHz system clock and an open-drain two-wire bus outside
package smt_pkg;

   // register map and reset values
   localparam logic [7:0] SMT_DATA_ADDR  = 8'hc2;  // serial_data_byte_reg
   localparam logic [7:0] SMT_DATA_RESET = 8'h00;

   // direction bit carried in the lsb of the address byte
   localparam logic SMT_DIR_WRITE = 1'b0;
   localparam logic SMT_DIR_READ  = 1'b1;

   // bus timing: least half period of the serial clock
   localparam int SMT_CLK_PERIOD_NS = 20;
   localparam int SMT_SCL_HALF_NS   = 80;
   localparam int SMT_SCL_HALF_CYC  =
      ((SMT_SCL_HALF_NS + SMT_CLK_PERIOD_NS - 1) / SMT_CLK_PERIOD_NS < 1) ? 1 :
      (SMT_SCL_HALF_NS + SMT_CLK_PERIOD_NS - 1) / SMT_CLK_PERIOD_NS;

   // operating mode: bit 1 is master, bit 0 is transmitter
   typedef enum logic [1:0] {
      SMT_MODE_SR = 2'b00,
      SMT_MODE_ST = 2'b01,
      SMT_MODE_MR = 2'b10,
      SMT_MODE_MT = 2'b11
   } smt_mode_t;

   // sequencer states
   typedef enum logic [3:0] {
      SMT_ST_IDLE     = 4'b0000,
      SMT_ST_START    = 4'b0001,
      SMT_ST_HOLD     = 4'b0010,
      SMT_ST_NEXT     = 4'b0011,
      SMT_ST_BIT_LO   = 4'b0100,
      SMT_ST_BIT_HI   = 4'b0101,
      SMT_ST_ACK_REQUEST_FLAG    = 4'b0110,
      SMT_ST_ACK_LO   = 4'b0111,
      SMT_ST_ACK_HI   = 4'b1000,
      SMT_ST_STOP_LO  = 4'b1001,
      SMT_ST_STOP_HI  = 4'b1010,
      SMT_ST_STOP_END = 4'b1011,
      SMT_ST_RS_LO    = 4'b1100,
      SMT_ST_RS_HI    = 4'b1101
   } smt_state_t;

endpackage

/* File: rtl/smt_sync.sv */
// smt_sync: two-stage synchroniser for a group of asynchronous inputs
// assumes: inputs may change at any time relative to mclk_i
`timescale 1ns/10ps
`default_nettype none
module smt_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             mclk_i,
   input  wire logic             reset_n_i,
   input  wire logic             ce_i,
   // asynchronous in, synchronised out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   ////////////////////////////////////////////////////////////////////////
   // one two-flop chain per bit; idle bus level is high
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic stage1;
         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               stage1    <= 1'b1;
               sync_o[g] <= 1'b1;
            end else if (ce_i) begin
               stage1    <= async_i[g];
               sync_o[g] <= stage1;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* File: bench/smt_slave_model.sv */
// smt_slave_model: behavioural remote slave on the two-wire bus
// assumes: scl_i and sda_i are the resolved wired-and lines with pull-ups
`timescale 1ns/10ps
`default_nettype none
module smt_slave_model #(
   parameter logic [7:0] RD_BASE = 8'h96
) (
   // resolved bus lines
   input  wire logic scl_i,
   input  wire logic sda_i,
   // pull-down of the data line
   output logic      sda_oe_o
);
   logic [7:0] rx [0:7];
   logic [7:0] mack;
   logic [7:0] tx;
   int         n;
   int         acks;
   int         k;
   ////////////////////////////////////////////////////////////////
   // one frame from start: acks every byte, sends bytes on a read
   initial sda_oe_o = 1'b0;
   always begin : frame
      do @(negedge sda_i); while (scl_i !== 1'b1);
      n = 0;
      acks = 0;
      forever begin
         for (k = 0; k < 8; k++) begin
            @(posedge scl_i);
            rx[n[2:0]][7-k] = sda_i;
         end
         @(negedge scl_i);
         sda_oe_o = 1'b1;
         @(negedge scl_i);
         sda_oe_o = 1'b0;
         n++;
         // read: send until the master answers with a nack
         while (rx[0][0] === 1'b1) begin
            tx = RD_BASE + 8'(acks);
            for (k = 0; k < 8; k++) begin
               sda_oe_o = ~tx[7-k];
               @(negedge scl_i);
            end
            sda_oe_o = 1'b0;
            @(posedge scl_i);
            mack[acks[2:0]] = ~sda_i;
            acks++;
            if (sda_i === 1'b1) wait (1'b0);
            @(negedge scl_i);
         end
      end
   end
   // stop seen: let go of the line and wait for the next start
   always @(posedge sda_i) begin
      if (scl_i === 1'b1) begin
         sda_oe_o = 1'b0;
         disable frame;
      end
   end
endmodule
`default_nettype wire

/* File: bench/tb_smbus_master_transfer_engine.sv */
// tb_smbus_master_transfer_engine: master write and read sequences against a slave model
// assumes: open-drain lines resolved here with pull-ups; ce_i held high
`timescale 1ns/10ps
`default_nettype none
module tb_smbus_master_transfer_engine;
   logic       mclk_i = 1'b0;
   logic       reset_n_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic       sfr_wr_i = 1'b0;
   logic       enable_i = 1'b0;
   logic       hw_ack_enable_i = 1'b0;
   logic [3:0] ctl_q = 4'h0;
   logic       ack_val_i = 1'b0;
   logic [7:0] sfr_rdata_o;
   logic       byte_done_flag_o, ack_request_flag_o, stop_request_bit_o;
   logic       master_o, tx_mode_o, ack_bit_o, arb_lost_o, scl_oe_o, sda_oe_o, slv_oe;
   logic       scl_lvl, sda_lvl;
   wire logic  scl;
   wire logic  sda;
   int         errors = 0;
   int         comparisons = 0;
   int         cycles = 0;
   ////////////////////////////////////////////////////////////////
   // clock, wired-and bus, design and slave
   always #10 mclk_i = ~mclk_i;
   assign scl = ~scl_oe_o;
   assign sda = ~(sda_oe_o | slv_oe);
   smt_engine DUT (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .enable_i(enable_i), .hw_ack_enable_i(hw_ack_enable_i), .start_set_i(ctl_q[0]),
      .stop_set_i(ctl_q[1]), .ack_wr_i(ctl_q[2]), .ack_val_i(ack_val_i),
      .done_clear_i(ctl_q[3]), .byte_done_flag_o(byte_done_flag_o),
      .ack_request_flag_o(ack_request_flag_o), .stop_request_bit_o(stop_request_bit_o),
      .master_o(master_o), .tx_mode_o(tx_mode_o), .ack_bit_o(ack_bit_o),
      .arb_lost_o(arb_lost_o), .scl_i(scl), .scl_o(scl_lvl), .scl_oe_o(scl_oe_o), .sda_i(sda),
      .sda_o(sda_lvl), .sda_oe_o(sda_oe_o));
   smt_slave_model SLV (.scl_i(scl), .sda_i(sda), .sda_oe_o(slv_oe));
   ////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // control pulse: bit 0 start, 1 stop, 2 ack write, 3 clear flag
   task automatic ctl(input logic [3:0] sel, input logic val);
      @(posedge mclk_i);
      ctl_q <= sel;
      ack_val_i <= val;
      @(posedge mclk_i);
      ctl_q <= 4'h0;
   endtask
   task automatic wr_data(input logic [7:0] d);
      @(posedge mclk_i);
      sfr_addr_i <= smt_pkg::SMT_DATA_ADDR;
      sfr_wr_i <= 1'b1;
      sfr_wdata_i <= d;
      @(posedge mclk_i);
      sfr_wr_i <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      sfr_addr_i <= a;
      repeat (2) @(posedge mclk_i);
      #1 d = sfr_rdata_o;
   endtask
   task automatic wait_done();
      // step past the edge so a flag cleared on it is not seen as still set
      #1;
      for (int i = 0; i < 3000 && byte_done_flag_o !== 1'b1; i++) begin
         @(posedge mclk_i);
         #1;
      end
      check("byte_done", {7'h0, byte_done_flag_o}, 8'h01);
      check("scl_held", {7'h0, scl}, 8'h00);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 3000 && master_o !== 1'b0; i++) begin
         @(posedge mclk_i);
         #1;
      end
      check("stopped", {5'h0, master_o, stop_request_bit_o, arb_lost_o}, 8'h00);
      check("bus_idle", {6'h0, scl, sda}, 8'h03);
   endtask
   ////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset();
      logic [7:0] d;
      rd_reg(smt_pkg::SMT_DATA_ADDR, d);
      check("reset_val", d, smt_pkg::SMT_DATA_RESET);
      rd_reg(8'h17, d);
      check("unmapped", d, 8'h00);
      check("status_rst", {1'b0, byte_done_flag_o, ack_request_flag_o, stop_request_bit_o,
                           master_o, tx_mode_o, ack_bit_o, arb_lost_o}, 8'h00);
      check("pins_low", {6'h0, scl_lvl, sda_lvl}, 8'h00);
      check("bus_free", {6'h0, scl, sda}, 8'h03);
      $display("test reset done");
   endtask
   task automatic test_write();
      logic [7:0] d;
      ctl(4'h1, 1'b0);
      wait_done();
      check("mode_mt", {6'h0, master_o, tx_mode_o}, 8'h03);
      wr_data({7'h2a, smt_pkg::SMT_DIR_WRITE});
      rd_reg(smt_pkg::SMT_DATA_ADDR, d);
      check("data_rw", d, 8'h54);
      for (int b = 0; b < 3; b++) begin
         ctl(4'h8, 1'b0);
         wait_done();
         check("ack_seen", {6'h0, ack_bit_o, tx_mode_o}, 8'h03);
         if (b < 2) wr_data(b == 0 ? 8'hc3 : 8'h3c);
      end
      ctl(4'h2, 1'b0);
      ctl(4'h8, 1'b0);
      wait_idle();
      check("wr_addr", SLV.rx[0], 8'h54);
      check("wr_data0", SLV.rx[1], 8'hc3);
      check("wr_data1", SLV.rx[2], 8'h3c);
      check("wr_count", 8'(SLV.n), 8'h03);
      $display("test write done");
   endtask
   task automatic test_read(input logic hw);
      logic [7:0] d;
      @(posedge mclk_i);
      hw_ack_enable_i <= hw;
      ctl(4'h5, 1'b1);
      wait_done();
      wr_data({7'h2a, smt_pkg::SMT_DIR_READ});
      ctl(4'h8, 1'b0);
      wait_done();
      check("mode_mr", {6'h0, master_o, tx_mode_o}, 8'h02);
      check("rd_addr", SLV.rx[0], 8'h55);
      for (int b = 0; b < 2; b++) begin
         if (hw) ctl(4'h4, b == 0);
         ctl(4'h8, 1'b0);
         wait_done();
         check("ack_req", {7'h0, ack_request_flag_o}, {7'h0, ~hw});
         check("ack_order", 8'(SLV.acks), 8'(b) + {7'h0, hw});
         rd_reg(smt_pkg::SMT_DATA_ADDR, d);
         check("rd_data", d, 8'h96 + 8'(b));
         if (!hw) ctl(4'h4, b == 0);
         if (b == 1) ctl(4'h2, 1'b0);
      end
      ctl(4'h8, 1'b0);
      wait_idle();
      check("master_ack", SLV.mack[1:0], 8'h01);
      $display("test read done");
   endtask
   ////////////////////////////////////////////////////////////////
   // verdict, hang limit and main sequence
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      enable_i <= 1'b1;
      test_reset();
      test_write();
      test_read(1'b0);
      test_read(1'b1);
      print_verdict();
   end
endmodule
`default_nettype wire
